// File: design/svcat_defs.vh
// Constants for the step VCO autotune calibrator.
// Included by the calibrator module; definitions only.
`ifndef SVCAT_DEFS_VH
`define SVCAT_DEFS_VH

// Register addresses
`define SVCAT_A_REFDIV 6'h03
`define SVCAT_A_TUNE 6'h0a
`define SVCAT_A_DIRECT 6'h0b
`define SVCAT_A_INTG 6'h0f
`define SVCAT_A_FRAC 6'h10
`define SVCAT_A_RESULT 6'h20

// Tuning configuration fields
`define SVCAT_T_AUTO 0
`define SVCAT_T_NCYC_LO 2
`define SVCAT_T_NCYC_HI 5
`define SVCAT_T_INV 6
`define SVCAT_T_SWAP 7
`define SVCAT_T_DIV_LO 10
`define SVCAT_T_DIV_HI 11

// Reset values
`define SVCAT_RST_REFDIV 14'h0001
`define SVCAT_RST_TUNE 12'h000
`define SVCAT_RST_DIRECT 10'h000
`define SVCAT_RST_INTG 16'h0000
`define SVCAT_RST_FRAC 24'h000000
`define SVCAT_RST_RESULT 8'h00

// Search and measurement
`define SVCAT_CODE_BITS 5
`define SVCAT_VCO_PRESCALE 5'h1f
`define SVCAT_FRAC_BITS 24
`define SVCAT_PRE_SHIFT 5
`define SVCAT_SETTLE_CYC 4'h4

// VCO serial frame
`define SVCAT_SER_BITS 16
`define SVCAT_SER_LAST 4'hf
`define SVCAT_SER_ADDR 6'h00

`endif

// File: design/svcat_calibrator.v
// Step VCO autotune calibrator: register file, measurement counter,
// successive-approximation switch search and VCO serial writer.
// Assumes reg_* strobes come from logic on ref_clk_i; vco_tick_i is a
// prescaled VCO signal from another domain, slow enough to sample.
`timescale 1ns/10ps
`include "svcat_defs.vh"

module svcat_calibrator (
   // Clock, reset, enable
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   // Register port
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [5:0] reg_addr_i,
   input wire [23:0] reg_wdata_i,
   output reg [23:0] reg_rdata_o,
   // VCO frequency sample pin
   input wire vco_tick_i,
   // VCO serial port
   output reg vco_sclk_o,
   output reg vco_sdata_o,
   output reg vco_sen_o,
   // Synthesizer side
   output reg [15:0] intg_active_o,
   output reg [23:0] frac_active_o,
   output reg freq_update_o,
   output reg vtune_hold_mid_o,
   output wire cal_busy_o
);

   localparam ST_IDLE = 3'd0;
   localparam ST_SER = 3'd1;
   localparam ST_SETTLE = 3'd2;
   localparam ST_MEAS = 3'd3;
   localparam ST_DECIDE = 3'd4;

   function [4:0] svcat_rev5;
      input [4:0] c;
      begin
         svcat_rev5 = {c[0], c[1], c[2], c[3], c[4]};
      end
   endfunction

   // Frame for the VCO: address then 10-bit data
   function [15:0] svcat_frame;
      input [9:0] d;
      begin
         svcat_frame = {`SVCAT_SER_ADDR, d};
      end
   endfunction

   reg rst_s1_q, rst_n_q;
   reg [13:0] refdiv_q;
   reg [11:0] tune_q;
   reg [9:0] direct_q;
   reg [15:0] intg_buf_q;
   reg [23:0] frac_buf_q;
   reg [7:0] result_q;
   reg [2:0] st_q;
   reg cal_q;
   reg [4:0] code_q, best_q;
   reg [2:0] bit_q;
   reg extra_q, finish_q, have_best_q;
   reg [23:0] best_err_q;
   reg [15:0] ser_sh_q;
   reg [3:0] ser_cnt_q;
   reg ser_ph_q;
   reg [3:0] settle_q;
   reg [19:0] win_q;
   reg [4:0] pre_q;
   reg [23:0] vco_measure_counter;
   reg vs1_q, vs2_q, vs3_q;

   wire [3:0] ncyc = tune_q[`SVCAT_T_NCYC_HI:`SVCAT_T_NCYC_LO];
   wire [1:0] rdiv = tune_q[`SVCAT_T_DIV_HI:`SVCAT_T_DIV_LO];
   wire [4:0] win_shift = {1'b0, ncyc} + {3'b000, rdiv};
   wire [19:0] win_len = 20'h00001 << win_shift;
   wire [39:0] n_val = {intg_active_o, frac_active_o};
   wire [63:0] n_scaled = {24'h000000, n_val} << win_shift;
   // VCO cycles over window, divided by the prescale of 32
   wire [23:0] target = n_scaled[`SVCAT_FRAC_BITS + `SVCAT_PRE_SHIFT +: 24];
   wire too_fast = vco_measure_counter > target;
   wire [23:0] err_abs = too_fast ? vco_measure_counter - target :
      target - vco_measure_counter;
   // Higher code lowers frequency unless inverted
   wire keep_bit = too_fast ^ tune_q[`SVCAT_T_INV];
   wire vco_edge = vs2_q & ~vs3_q;
   wire frac_wr = reg_wr_i && reg_addr_i == `SVCAT_A_FRAC;
   wire [4:0] shaped = tune_q[`SVCAT_T_SWAP] ? svcat_rev5(code_q) : code_q;
   wire [4:0] shaped_best = tune_q[`SVCAT_T_SWAP] ? svcat_rev5(best_q) : best_q;
   // Next step's code: tested bit kept or cleared, next lower bit set
   wire [4:0] next_code = (code_q & ~(keep_bit ? 5'h00 : 5'h01 << bit_q)) |
      (5'h01 << (bit_q - 3'd1));

   assign cal_busy_o = cal_q;

   // Reset release through two flip-flops
   always @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // VCO sample pin synchroniser plus edge history
   always @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         vs1_q <= 1'b0;
         vs2_q <= 1'b0;
         vs3_q <= 1'b0;
      end else if (ce_i) begin
         vs1_q <= vco_tick_i;
         vs2_q <= vs1_q;
         vs3_q <= vs2_q;
      end
   end

   // Register file and read port
   always @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         refdiv_q <= `SVCAT_RST_REFDIV;
         tune_q <= `SVCAT_RST_TUNE;
         direct_q <= `SVCAT_RST_DIRECT;
         intg_buf_q <= `SVCAT_RST_INTG;
         frac_buf_q <= `SVCAT_RST_FRAC;
         reg_rdata_o <= 24'h000000;
      end else if (ce_i) begin
         if (reg_wr_i) begin
            case (reg_addr_i)
               `SVCAT_A_REFDIV: refdiv_q <= reg_wdata_i[13:0];
               `SVCAT_A_TUNE: tune_q <= reg_wdata_i[11:0];
               `SVCAT_A_DIRECT: direct_q <= reg_wdata_i[9:0];
               `SVCAT_A_INTG: intg_buf_q <= reg_wdata_i[15:0];
               `SVCAT_A_FRAC: frac_buf_q <= reg_wdata_i;
               default: ;
            endcase
         end
         if (reg_rd_i) begin
            case (reg_addr_i)
               `SVCAT_A_REFDIV: reg_rdata_o <= {10'h000, refdiv_q};
               `SVCAT_A_TUNE: reg_rdata_o <= {12'h000, tune_q};
               `SVCAT_A_DIRECT: reg_rdata_o <= {14'h0000, direct_q};
               `SVCAT_A_INTG: reg_rdata_o <= {8'h00, intg_buf_q};
               `SVCAT_A_FRAC: reg_rdata_o <= frac_buf_q;
               `SVCAT_A_RESULT: reg_rdata_o <= {16'h0000, result_q};
               default: reg_rdata_o <= 24'h000000;
            endcase
         end
      end
   end

   // Sequencer: frequency change, search, serial writes
   always @(posedge ref_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= ST_IDLE;
         cal_q <= 1'b0;
         intg_active_o <= `SVCAT_RST_INTG;
         frac_active_o <= `SVCAT_RST_FRAC;
         freq_update_o <= 1'b0;
         vtune_hold_mid_o <= 1'b0;
         result_q <= `SVCAT_RST_RESULT;
         code_q <= 5'h00;
         best_q <= 5'h00;
         bit_q <= 3'd0;
         extra_q <= 1'b0;
         finish_q <= 1'b0;
         have_best_q <= 1'b0;
         best_err_q <= 24'h000000;
         ser_sh_q <= 16'h0000;
         ser_cnt_q <= 4'h0;
         ser_ph_q <= 1'b0;
         settle_q <= 4'h0;
         win_q <= 20'h00000;
         pre_q <= 5'h00;
         vco_measure_counter <= 24'h000000;
         vco_sclk_o <= 1'b0;
         vco_sdata_o <= 1'b0;
         vco_sen_o <= 1'b0;
      end else if (ce_i) begin
         freq_update_o <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               // Requests while busy never reach here
               if (frac_wr) begin
                  intg_active_o <= intg_buf_q;
                  frac_active_o <= reg_wdata_i;
                  freq_update_o <= 1'b1;
                  ser_cnt_q <= 4'h0;
                  ser_ph_q <= 1'b0;
                  st_q <= ST_SER;
                  if (tune_q[`SVCAT_T_AUTO]) begin
                     cal_q <= 1'b1;
                     vtune_hold_mid_o <= 1'b1;
                     code_q <= 5'h10;
                     bit_q <= 3'd4;
                     extra_q <= 1'b0;
                     finish_q <= 1'b0;
                     have_best_q <= 1'b0;
                     ser_sh_q <= svcat_frame({5'h00, tune_q[`SVCAT_T_SWAP] ?
                        svcat_rev5(5'h10) : 5'h10});
                  end else begin
                     ser_sh_q <= svcat_frame(direct_q);
                  end
               end
            end
            ST_SER: begin
               vco_sen_o <= 1'b1;
               if (!ser_ph_q) begin
                  vco_sclk_o <= 1'b0;
                  vco_sdata_o <= ser_sh_q[`SVCAT_SER_BITS - 1];
                  ser_ph_q <= 1'b1;
               end else begin
                  // VCO samples on the rising edge
                  vco_sclk_o <= 1'b1;
                  ser_ph_q <= 1'b0;
                  ser_sh_q <= {ser_sh_q[14:0], 1'b0};
                  ser_cnt_q <= ser_cnt_q + 4'h1;
                  if (ser_cnt_q == `SVCAT_SER_LAST) begin
                     settle_q <= `SVCAT_SETTLE_CYC;
                     st_q <= ST_SETTLE;
                  end
               end
            end
            ST_SETTLE: begin
               vco_sclk_o <= 1'b0;
               vco_sen_o <= 1'b0;
               vco_sdata_o <= 1'b0;
               // Gives the VCO switch time to land before counting
               if (settle_q != 4'h0) begin
                  settle_q <= settle_q - 4'h1;
               end else if (!cal_q) begin
                  st_q <= ST_IDLE;
               end else if (finish_q) begin
                  cal_q <= 1'b0;
                  vtune_hold_mid_o <= 1'b0;
                  st_q <= ST_IDLE;
               end else begin
                  win_q <= win_len;
                  pre_q <= 5'h00;
                  vco_measure_counter <= 24'h000000;
                  st_q <= ST_MEAS;
               end
            end
            ST_MEAS: begin
               if (vco_edge) begin
                  pre_q <= pre_q + 5'h01;
                  if (pre_q == `SVCAT_VCO_PRESCALE) begin
                     vco_measure_counter <= vco_measure_counter + 24'h000001;
                  end
               end
               win_q <= win_q - 20'h00001;
               if (win_q == 20'h00001) begin
                  st_q <= ST_DECIDE;
               end
            end
            ST_DECIDE: begin
               if (!have_best_q || err_abs < best_err_q) begin
                  best_q <= code_q;
                  best_err_q <= err_abs;
                  have_best_q <= 1'b1;
               end
               ser_cnt_q <= 4'h0;
               ser_ph_q <= 1'b0;
               st_q <= ST_SER;
               if (!extra_q && !keep_bit) begin
                  code_q[bit_q] <= 1'b0;
               end
               if (!extra_q && bit_q != 3'd0) begin
                  code_q[bit_q - 3'd1] <= 1'b1;
                  bit_q <= bit_q - 3'd1;
                  // Shape after building the code, so swap cannot scramble the masks
                  ser_sh_q <= svcat_frame({5'h00, tune_q[`SVCAT_T_SWAP] ?
                     svcat_rev5(next_code) : next_code});
               end else if (!extra_q && !keep_bit) begin
                  // Cleared LSB leaves one code unmeasured: sixth step
                  extra_q <= 1'b1;
                  ser_sh_q <= svcat_frame({5'h00, tune_q[`SVCAT_T_SWAP] ?
                     svcat_rev5({code_q[4:1], 1'b0}) : {code_q[4:1], 1'b0}});
               end else begin
                  finish_q <= 1'b1;
                  if (have_best_q && err_abs >= best_err_q) begin
                     result_q <= {3'b000, best_q};
                     ser_sh_q <= svcat_frame({5'h00, shaped_best});
                  end else begin
                     result_q <= {3'b000, code_q};
                     ser_sh_q <= svcat_frame({5'h00, shaped});
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

endmodule

// File: bench/svcat_calibrator_sva.sv
// Port checker for the calibrator, bound to every calibrator instance.
// Assumes ce_i is lowered only while idle, and one reference clock domain.
`timescale 1ns/10ps
module svcat_calibrator_chk (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   // Register port
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [5:0] reg_addr_i,
   input wire [23:0] reg_wdata_i,
   input wire [23:0] reg_rdata_o,
   // VCO and synthesizer side
   input wire vco_sclk_o,
   input wire vco_sdata_o,
   input wire vco_sen_o,
   input wire [23:0] frac_active_o,
   input wire freq_update_o,
   input wire vtune_hold_mid_o,
   input wire cal_busy_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   frame_len_a: assert property (
      $rose(vco_sen_o) |-> ##31 vco_sen_o ##1 !vco_sen_o) else $error("frame length wrong");
   sclk_idle_a: assert property (
      !vco_sen_o |-> !vco_sclk_o) else $error("serial clock outside frame");
   data_hold_a: assert property (
      vco_sclk_o |-> $stable(vco_sdata_o)) else $error("serial data moved at clock high");
   pulse_one_a: assert property (
      freq_update_o |=> !freq_update_o) else $error("update pulse too long");
   update_cause_a: assert property (
      freq_update_o |-> $past(reg_wr_i && reg_addr_i == 6'h10)) else $error("update w/o frac");
   frac_apply_a: assert property (
      freq_update_o |-> frac_active_o == $past(reg_wdata_i)) else $error("fraction not applied");
   cal_start_a: assert property (
      $rose(cal_busy_o) |-> freq_update_o ##1 vco_sen_o) else $error("calibration start wrong");
   hold_mid_a: assert property (
      vtune_hold_mid_o == cal_busy_o) else $error("tune hold differs from busy");
   busy_quiet_a: assert property (
      cal_busy_o && $past(cal_busy_o) |-> !freq_update_o) else $error("change taken while busy");
   busy_end_a: assert property (
      $fell(cal_busy_o) |-> !vco_sen_o && !$past(vco_sen_o)) else $error("busy ended in frame");
   result_read_a: assert property (
      reg_rd_i && reg_addr_i == 6'h20 |=> reg_rdata_o[23:8] == 16'h0000)
      else $error("result upper bits set");
endmodule

bind svcat_calibrator svcat_calibrator_chk u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .vco_sclk_o(vco_sclk_o), .vco_sdata_o(vco_sdata_o), .vco_sen_o(vco_sen_o),
   .frac_active_o(frac_active_o), .freq_update_o(freq_update_o),
   .vtune_hold_mid_o(vtune_hold_mid_o), .cal_busy_o(cal_busy_o));

// File: bench/svcat_vco_model.sv
// Behavioural step-tuned VCO: takes serial frames, toggles a tick pin.
// Assumes 16-bit frames, MSB first, sampled on the rising serial clock.
`timescale 1ns/10ps
module svcat_vco_model (
   // Serial port
   input wire sclk_i,
   input wire sdata_i,
   input wire sen_i,
   // Board wiring of the switch bits
   input wire flip_i,
   // Outputs
   output logic tick_o,
   output logic [15:0] word_o
);
   logic [15:0] shift_q = 16'h0000;
   logic [4:0] code;
   int k;
   initial word_o = 16'h0000;
   initial tick_o = 1'b0;
   always @(posedge sclk_i) if (sen_i) shift_q <= {shift_q[14:0], sdata_i};
   // New setting takes effect when the frame closes
   always @(negedge sen_i) word_o <= shift_q;
   // Reversed wiring pairs with the swapped code order
   assign code = flip_i ? {word_o[0], word_o[1], word_o[2], word_o[3], word_o[4]} : word_o[4:0];
   // Higher code runs slower; half a count of offset makes counts phase-proof
   always begin
      k = (code > 5'd24) ? 0 : 24 - code;
      #(3200.0 / (k + 0.5)) tick_o = ~tick_o;
   end
endmodule

// File: bench/tb_svcat_calibrator.sv
// Testbench for the calibrator: register tasks, manual and automatic changes.
// Assumes the VCO model beside it; the port checker is bound separately.
`timescale 1ns/10ps
module tb_svcat_calibrator;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic flip = 1'b0;
   logic ce = 1'b1;
   logic [5:0] addr = 6'h00;
   logic [23:0] wdata = 24'h000000;
   wire [23:0] rdata_w, frac_w;
   wire [15:0] intg_w, word_w;
   wire sclk, sdata, sen, tick, upd, busy;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int busy_n;
   svcat_calibrator u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata_w), .vco_tick_i(tick), .vco_sclk_o(sclk), .vco_sdata_o(sdata),
      .vco_sen_o(sen), .intg_active_o(intg_w), .frac_active_o(frac_w),
      .freq_update_o(upd), .vtune_hold_mid_o(), .cal_busy_o(busy));
   svcat_vco_model u_vco (.sclk_i(sclk), .sdata_i(sdata), .sen_i(sen), .flip_i(flip),
      .tick_o(tick), .word_o(word_w));
   always #25 ref_clk_i = ~ref_clk_i;
   task automatic end_of_test;
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic put_reg(input logic [5:0] a, input logic [23:0] d);
      @(negedge ref_clk_i);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk_i);
      reg_wr = 1'b0;
   endtask
   task automatic look(input string what, input logic [5:0] a, input logic [23:0] exp);
      @(negedge ref_clk_i);
      addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk_i);
      reg_rd = 1'b0;
      chk(what, rdata_w, exp);
   endtask
   // Count of 12 keeps each window at 4096 cycles
   task automatic cal_run(input logic [11:0] tune, input logic [23:0] res,
         input logic [15:0] word, input int meas);
      put_reg(6'h03, 24'h000001);
      put_reg(6'h0f, 24'h000000);
      put_reg(6'h0a, {12'h000, tune});
      put_reg(6'h10, 24'h120000);
      put_reg(6'h10, 24'h777777);
      busy_n = 3;
      while (busy === 1'b1 && busy_n < 30000) begin
         @(negedge ref_clk_i);
         busy_n++;
      end
      chk("cal time", busy_n >= meas * 4096 && busy_n <= meas * 4096 + 400, 1'b1);
      chk("frac kept", frac_w, 24'h120000);
      look("result", 6'h20, res);
      chk("vco word", word_w, word);
   endtask
   initial begin
      repeat (10) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      look("refdiv", 6'h03, 24'h000001);
      look("tune", 6'h0a, 24'h000000);
      put_reg(6'h20, 24'h0000ff);
      look("result ro", 6'h20, 24'h000000);
      look("unmapped", 6'h3f, 24'h000000);
      put_reg(6'h0f, 24'h000005);
      chk("intg held", intg_w, 16'h0000);
      put_reg(6'h0b, 24'h0002a5);
      put_reg(6'h10, 24'h0abcde);
      chk("update", upd, 1'b1);
      chk("intg", intg_w, 16'h0005);
      chk("frac", frac_w, 24'h0abcde);
      repeat (45) @(negedge ref_clk_i);
      chk("manual word", word_w, 16'h02a5);
      chk("manual busy", busy, 1'b0);
      // Write with the enable low must not land
      ce = 1'b0;
      put_reg(6'h0b, 24'h000155);
      ce = 1'b1;
      look("frozen", 6'h0b, 24'h0002a5);
      cal_run(12'h031, 24'h00000f, 16'h000f, 6);
      flip = 1'b1;
      cal_run(12'h0f1, 24'h000010, 16'h0001, 5);
      end_of_test();
   end
endmodule
